//--- hdl/eqsm_pkg.sv
/*
  Package for the event queue status monitor: register offsets, field positions,
  reset values and the carrier structs. Assumes a 32-bit AHB-Lite register bus.
*/
package eqsm_pkg;
  localparam int NQ = 4;
  localparam logic [4:0] DEPTH = 5'h10;
  // byte offsets
  localparam logic [7:0] OFS_QSTAT0 = 8'h00; // queue_status 0..3 at 00,04,08,0C
  localparam logic [7:0] OFS_THR = 8'h10; // queue_threshold_register
  localparam logic [7:0] OFS_ERR = 8'h14; // error_register (RO, sticky)
  localparam logic [7:0] OFS_ERRCLR = 8'h18; // error_clear_register (WO, W1C)
  localparam logic [7:0] OFS_IEN = 8'h1C; // interrupt enable
  // queue_status field positions
  localparam int POS_HEAD = 0;
  localparam int POS_COUNT = 8;
  localparam int POS_HWM = 16;
  localparam int POS_THRX = 24;
  localparam int THR_STRIDE = 8;
  localparam logic [4:0] THR_RESET = 5'h10;
  localparam logic [4:0] THR_DISABLE = 5'h11;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic [4:0] count;
    logic [3:0] head;
    logic [4:0] hwm;
    logic thrx;
    logic [4:0] thr;
  } eqsm_queue_s;

  typedef struct packed {
    eqsm_queue_s [NQ-1:0] q;
    logic [NQ-1:0] ien;
    logic dph_valid;
    logic dph_write;
    logic [7:0] dph_addr;
    logic [31:0] rdata;
  } eqsm_state_s;

  typedef struct packed {
    logic [NQ-1:0] enq;
    logic [NQ-1:0] deq;
  } eqsm_qev_s;
endpackage

//--- hdl/eqsm_top.sv
/*
  Event queue status monitor. Tracks count, head offset, high-water mark and a
  sticky threshold flag per queue from enqueue/dequeue strobes. Assumes strobes
  are synchronous to clock and the source never enqueues into a full queue nor
  dequeues from an empty one. Single AHB-Lite slave, zero wait states.
*/
// Our own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module eqsm_top (
  input wire logic clock, // 25 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic clk_en, // freezes all state when low
  input wire eqsm_pkg::eqsm_qev_s qev, // per-queue enqueue/dequeue strobes
  input wire logic hsel, // ahb select
  input wire logic [31:0] haddr, // ahb address
  input wire logic [1:0] htrans, // ahb transfer type
  input wire logic hwrite, // ahb write
  input wire logic [2:0] hsize, // ahb size
  input wire logic [31:0] hwdata, // ahb write data
  input wire logic hready, // ahb ready in
  output logic [31:0] hrdata, // ahb read data
  output logic hreadyout, // ahb ready out
  output logic hresp, // ahb response
  output logic [eqsm_pkg::NQ-1:0] error_register, // sticky threshold errors
  output logic irq // level interrupt
);
  import eqsm_pkg::*;

  eqsm_state_s s_q, s_d;

  function automatic logic [31:0] status_word(input eqsm_queue_s q);
    logic [31:0] w;
    w = 32'h0;
    w[POS_HEAD +: 4] = q.head;
    w[POS_COUNT +: 5] = q.count;
    w[POS_HWM +: 5] = q.hwm;
    w[POS_THRX] = q.thrx;
    return w;
  endfunction

  logic addr_take;
  logic [NQ-1:0] clr_bits;
  logic [NQ-1:0] thrx_vec;

  assign addr_take = hsel && hready && (htrans == HTRANS_NONSEQ);
  // the write data of a clear arrives in the data phase
  assign clr_bits = (s_q.dph_valid && s_q.dph_write && s_q.dph_addr == OFS_ERRCLR)
    ? hwdata[NQ-1:0] : '0;

  always_comb begin
    logic [31:0] rd;
    logic [4:0] cnt;
    rd = 32'h0;
    cnt = 5'h0;
    s_d = s_q;
    // queue tracking
    for (int i = 0; i < NQ; i++) begin
      cnt = s_q.q[i].count;
      if (qev.enq[i] && !qev.deq[i] && cnt != DEPTH) begin
        cnt = cnt + 5'h1;
      end else if (qev.deq[i] && !qev.enq[i] && cnt != 5'h0) begin
        cnt = cnt - 5'h1;
      end
      // judge emptiness on the old count, so the last entry out still moves the head
      if (qev.deq[i] && (s_q.q[i].count != 5'h0 || qev.enq[i])) begin
        s_d.q[i].head = s_q.q[i].head + 4'h1;
      end
      s_d.q[i].count = cnt;
      if (clr_bits[i]) begin
        s_d.q[i].hwm = cnt;
      end else if (cnt > s_q.q[i].hwm) begin
        s_d.q[i].hwm = cnt;
      end
      if (s_q.q[i].thr != THR_DISABLE && cnt >= s_q.q[i].thr) begin
        s_d.q[i].thrx = 1'b1; // set wins over clear
      end else if (clr_bits[i]) begin
        s_d.q[i].thrx = 1'b0;
      end
    end
    // bus writes
    if (s_q.dph_valid && s_q.dph_write) begin
      if (s_q.dph_addr == OFS_THR) begin
        for (int i = 0; i < NQ; i++) begin
          s_d.q[i].thr = hwdata[i*THR_STRIDE +: 5];
        end
      end else if (s_q.dph_addr == OFS_IEN) begin
        s_d.ien = hwdata[NQ-1:0];
      end
    end
    // address phase capture, read data registered for the data phase
    s_d.dph_valid = addr_take;
    s_d.dph_write = hwrite;
    s_d.dph_addr = haddr[7:0];
    if (addr_take && !hwrite) begin
      if (haddr[7:0] < OFS_THR && haddr[1:0] == 2'h0) begin
        rd = status_word(s_q.q[haddr[3:2]]);
      end else if (haddr[7:0] == OFS_THR) begin
        for (int i = 0; i < NQ; i++) begin
          rd[i*THR_STRIDE +: 5] = s_q.q[i].thr;
        end
      end else if (haddr[7:0] == OFS_ERR) begin
        rd[NQ-1:0] = thrx_vec;
      end else if (haddr[7:0] == OFS_IEN) begin
        rd[NQ-1:0] = s_q.ien;
      end else begin
        rd = 32'h0;
      end
    end
    // read data stands until the next read is taken; writes leave it alone
    if (addr_take && !hwrite) begin
      s_d.rdata = rd;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NQ; g++) begin : g_err
      assign thrx_vec[g] = s_q.q[g].thrx;
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
      for (int i = 0; i < NQ; i++) begin
        s_q.q[i].thr <= THR_RESET;
      end
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign hrdata = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign error_register = thrx_vec;
  assign irq = |(thrx_vec & s_q.ien);
endmodule // eqsm_top
`default_nettype wire

//--- bench/eqsm_top_asserts.sv
/* port checker for eqsm_top; bound to every eqsm_top instance */
`timescale 1ns/1ps
`default_nettype none
module eqsm_chk (
  input wire logic clock, // clock
  input wire logic rst_n, // reset
  input wire logic clk_en, // run
  input wire logic hsel, // select
  input wire logic [31:0] haddr, // address
  input wire logic [1:0] htrans, // transfer
  input wire logic hwrite, // write
  input wire logic hready, // ready in
  input wire logic [31:0] hrdata, // read data
  input wire logic hreadyout, // ready out
  input wire logic hresp, // response
  input wire logic [3:0] error_register, // errors
  input wire logic irq // interrupt
);
  logic tk, rd, wc_q;
  assign tk = hsel & hready & clk_en & (htrans == 2'h2);
  assign rd = tk & !hwrite;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) wc_q <= 1'b0;
    else wc_q <= tk & hwrite & (haddr[7:0] == 8'h18);
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_rdy; hreadyout && !hresp; endproperty
  a_rdy: assert property (p_rdy) else $error("bus not ready or error");
  property p_irq; irq |-> error_register != 4'h0; endproperty
  a_irq: assert property (p_irq) else $error("irq without error");
  property p_fall; |($past(error_register) & ~error_register) |-> $past(wc_q); endproperty
  a_fall: assert property (p_fall) else $error("flag fell unasked");
  property p_hold; $changed(hrdata) |-> $past(rd); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_rsv; rd && haddr[7:0] < 8'h10 |=> (hrdata & 32'hFEE0E0F0) == 32'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_cnt; rd && haddr[7:0] < 8'h10 |=> hrdata[12:8] <= 5'h10; endproperty
  a_cnt: assert property (p_cnt) else $error("count out of range");
  property p_hwm; rd && haddr[7:0] < 8'h10 |=> hrdata[20:16] >= hrdata[12:8]; endproperty
  a_hwm: assert property (p_hwm) else $error("mark below count");
  property p_unm; rd && haddr[7:0] >= 8'h20 |=> hrdata == 32'h0; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read nonzero");
endmodule // eqsm_chk
bind eqsm_top eqsm_chk eqsm_chk_i (.clock, .rst_n, .clk_en, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hrdata, .hreadyout, .hresp, .error_register, .irq);
`default_nettype wire

//--- bench/eqsm_top_tb.sv
/* self-checking bench for eqsm_top; drives the bus and queue strobes itself */
`timescale 1ns/1ps
`default_nettype none
module eqsm_top_tb;
  import eqsm_pkg::*;
  logic clock = 0, rst_n = 0, hwrite = 0, irq, hreadyout, hresp;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [3:0] error_register;
  eqsm_qev_s qev = '0;
  int error_cnt = 0, compares = 0;
  logic [39:0] rows [8] = '{40'h0000000000, 40'h0400000000, 40'h0800000000,
    40'h0C00000000, 40'h1010101010, 40'h1400000000, 40'h1C00000000, 40'h2000000000};
  eqsm_top eqsm_top_i (.clock, .rst_n, .clk_en(1'b1), .qev, .hsel(1'b1), .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .error_register, .irq);
  initial forever #20 clock = ~clock;
  task automatic finish_test;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wt;
    int n;
    n = 0;
    do begin @(posedge clock); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin error_cnt++; finish_test; end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    wt;
    htrans <= 2'h0; hwdata <= d;
    wt;
    r = hrdata;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      error_cnt++;
    end
  endtask
  task automatic ev(input eqsm_qev_s e, input int n);
    qev <= e;
    repeat (n) @(posedge clock);
    qev <= '0;
    @(posedge clock);
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1;
    @(posedge clock);
    foreach (rows[i]) begin
      bus(0, rows[i][39:32], 0);
      chk(r, rows[i][31:0]);
    end
    $display("reset values done");
    ev(8'h20, 3); ev(8'h02, 1); bus(0, 8'h04, 0);
    chk(r, 32'h00030201);
    $display("occupancy done");
    bus(1, 8'h10, 32'h11101002); ev(8'h10, 2);
    chk(error_register, 1);
    chk(irq, 0);
    bus(1, 8'h1C, 1); @(posedge clock);
    chk(irq, 1);
    bus(1, 8'h00, '1); bus(0, 8'h00, 0);
    chk(r, 32'h01020200);
    ev(8'h01, 1); bus(1, 8'h18, 1); bus(0, 8'h00, 0);
    chk(r, 32'h00010101);
    $display("threshold done");
    ev(8'h02, 2); bus(0, 8'h04, 0);
    chk(r, 32'h00030003);
    $display("drain done");
    ev(8'h80, 17); bus(0, 8'h0C, 0);
    chk(r, 32'h00101000);
    chk(error_register, 0);
    $display("disable done");
    finish_test;
  end
endmodule // eqsm_top_tb
`default_nettype wire
